// [rtl/flash_address_space_map.sv]
// Overview of operation
// [R1] Legacy commands use 24-bit addresses, reaching the first 16 MBytes.
// [R2] Extended mode bit set makes legacy commands expect four address bytes.
// [R3] Four-byte command variants always expect a 32-bit address.
// [R4] Extended mode loads from its nonvolatile default after every reset.
// [R5] Non-array spaces still take the full address width; few bytes exist.
// [R6] Array splits into 64 KB blocks, 32 KB halves, 4 KB sectors, aligned.
// [R7] Identification read uses its own read-only space.
// [R8] Identification space holds an eight-byte unique serial number.
// [R9] Parameter read uses its own read-only space containing the ID space.
// [R10] Security space is 1024 bytes in four 256-byte regions.
// [R11] Regions ship erased; unprotected ones program and erase individually.
// [R12] Lock bits [5:2] permanently block program and erase per region.
// [R13] Volatile region lock blocks program and erase of regions 2 and 3.
// [R14] Password protection bit blocks regions 2 and 3 until password given.
// [R15] Read protection bit hides region 3 reads until password given.
// [R16] Blocked program or erase sets program or erase error flag.
// [R17] Array decodes 128 blocks, 256 halves, 2048 sectors up to 7FFFFFh.
module flash_address_space_map
  import flash_map_pkg::*;
#(
  // Arbitrary identification values
  parameter logic [63:0] ID_HEADER = 64'hFFFF_FFFF_FF00_A5C3,
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF
)
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       softReset,
  input  wire logic       extAddrDefault,
  input  wire logic       extAddrWrite,
  input  wire logic       extAddrValue,
  output logic            extAddrMode,
  input  wire logic [7:0] configOneNonvolatile,
  input  wire logic       volatileRegionLock,
  input  wire logic [15:0] regionProtectionReg,
  input  wire logic       passwordOk,
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire cmd_req_t   cmdReq,
  output logic            respValid,
  output map_resp_t       resp,
  output logic [7:0]      readData,
  output logic            busy,
  input  wire logic       clearStatus,
  output logic [7:0]      statusTwoVolatile
);

  function automatic space_t opSpace(input op_t op);
    unique case (op)
      OP_ID_READ:                            return SPACE_ID;
      OP_SFDP_READ:                          return SPACE_SFDP;
      OP_SEC_READ, OP_SEC_PROG, OP_SEC_ERASE: return SPACE_SEC;
      default:                               return SPACE_ARRAY;
    endcase
  endfunction : opSpace

  function automatic logic opIsProgram(input op_t op);
    return (op == OP_ARRAY_PROG) || (op == OP_SEC_PROG);
  endfunction : opIsProgram

  function automatic logic opIsErase(input op_t op);
    return (op == OP_SECTOR_ERASE) || (op == OP_HALF_ERASE) ||
           (op == OP_BLOCK_ERASE) || (op == OP_SEC_ERASE);
  endfunction : opIsErase

  function automatic logic [31:0] eraseMask(input op_t op);
    unique case (op)
      OP_SECTOR_ERASE: return SECTOR_MASK;
      OP_HALF_ERASE:   return HALF_MASK;
      OP_BLOCK_ERASE:  return BLOCK_MASK;
      OP_SEC_ERASE:    return REGION_MASK;
      default:         return 32'h0000_0000;
    endcase
  endfunction : eraseMask

  // Identification byte, shared by both read spaces
  function automatic logic [7:0] idByte(input logic [3:0] ofs);
    logic [5:0] bitPos;
    bitPos = {ofs[2:0], 3'h0};
    return ofs[3] ? UNIQUE_ID[bitPos +: 8] : ID_HEADER[bitPos +: 8];
  endfunction : idByte

  state_t     stateReg;
  state_t     stateNext;
  logic       loadPendReg;
  logic       extModeReg;
  logic       take;
  logic [2:0] expectBytes;
  logic       widthOk;
  logic [31:0] effAddr;
  space_t     reqSpace;
  logic       reqModify;
  logic       inRange;
  logic [1:0] reqRegion;
  logic [3:0] lockBits;
  logic       tempProt;
  logic       modifyBlocked;
  logic       readBlocked;
  logic       protFail;
  map_resp_t  decode;
  map_resp_t  pendReg;
  op_t        opReg;
  logic [7:0] dataReg;
  logic [7:0] eraseCntReg;
  logic       eraseDone;
  logic [7:0] memRd;
  logic       memWrEn;
  logic [SEC_ADDR_W-1:0] memWrAddr;
  logic [7:0] memWrData;
  logic [7:0] readByte;
  logic [7:0] sfdpByte;
  logic [4:0] sigPos;
  logic       respValidReg;
  map_resp_t  respReg;
  logic [7:0] readDataReg;
  logic       progErrReg;
  logic       eraseErrReg;
  logic       progErrSet;
  logic       eraseErrSet;

  // Requests are held off while the mode bit is still loading
  assign cmdReady = (stateReg == ST_IDLE) && !loadPendReg;
  assign take     = cmdValid && cmdReady;
  assign busy     = (stateReg != ST_IDLE);

  // [R3] Four-byte variants
  // [R2] Extended mode widens legacy
  assign expectBytes = (cmdReq.fourByte || extModeReg) ?
                       EXT_ADDR_BYTES : LEGACY_ADDR_BYTES;
  // [R5] Full width everywhere
  assign widthOk = (cmdReq.addrBytes == expectBytes);
  // [R1] Legacy address clipped
  assign effAddr = (expectBytes == LEGACY_ADDR_BYTES) ?
                   {8'h00, cmdReq.addr[LEGACY_ADDR_W-1:0]} : cmdReq.addr;

  assign reqSpace  = opSpace(cmdReq.op);
  assign reqModify = opIsProgram(cmdReq.op) || opIsErase(cmdReq.op);

  // [R17] Array range check
  // [R10] Security space range
  // Identification and parameter spaces read FF where unpopulated
  assign inRange = (reqSpace == SPACE_ARRAY) ? (effAddr <= ARRAY_LAST_ADDR) :
                   (reqSpace == SPACE_SEC)   ? (effAddr <= SEC_LAST_ADDR) :
                   1'b1;

  // [R10] Region number
  assign reqRegion = effAddr[REGION_LSB+1:REGION_LSB];

  // [R12] Permanent lock bits
  assign lockBits = configOneNonvolatile[LOCK_LSB+3:LOCK_LSB];
  // [R13] Volatile region lock
  // [R14] Password protection
  assign tempProt = volatileRegionLock ||
                    (regionProtectionReg[PWD_PROT_BIT] && !passwordOk);
  assign modifyBlocked = lockBits[reqRegion] ||
                         ((reqRegion >= TEMP_PROT_FIRST) && tempProt);
  // [R15] Region read protection
  assign readBlocked = (reqRegion == READ_PROT_REGION) &&
                       regionProtectionReg[READ_PROT_BIT] && !passwordOk;

  // [R16] Blocked modify fails
  assign protFail = (reqSpace == SPACE_SEC) && reqModify && modifyBlocked &&
                    widthOk && inRange;

  // [R6] Erase unit decode
  always_comb begin
    decode                = '0;
    decode.space          = reqSpace;
    decode.addrError      = !widthOk;
    decode.rangeError     = widthOk && !inRange;
    decode.protError      = protFail;
    decode.accept         = widthOk && inRange && !protFail;
    decode.readProtected  = (reqSpace == SPACE_SEC) && readBlocked;
    decode.region         = reqRegion;
    decode.addr           = effAddr;
    decode.eraseBase      = effAddr & ~eraseMask(cmdReq.op);
    decode.sectorIndex    = effAddr[ARRAY_MSB:SECTOR_LSB];
    decode.halfBlockIndex = effAddr[ARRAY_MSB:HALF_LSB];
    decode.blockIndex     = effAddr[ARRAY_MSB:BLOCK_LSB];
  end

  // [R4] Default loaded at release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      loadPendReg <= 1'b1;
      extModeReg  <= 1'b0;
    end else if (loadPendReg) begin
      loadPendReg <= 1'b0;
      extModeReg  <= extAddrDefault;
    end else if (softReset) begin
      loadPendReg <= 1'b1;
    end else if (extAddrWrite) begin
      extModeReg  <= extAddrValue;
    end
  end

  assign extAddrMode = extModeReg;

  // Request capture
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pendReg <= '0;
      opReg   <= OP_ARRAY_READ;
      dataReg <= 8'h00;
    end else if (take) begin
      pendReg <= decode;
      opReg   <= cmdReq.op;
      dataReg <= cmdReq.data;
    end
  end

  assign eraseDone = (eraseCntReg == REGION_LAST_OFS);

  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_IDLE: begin
        if (take) begin
          stateNext = ST_RESP;
        end
      end
      ST_RESP: begin
        if ((opReg == OP_SEC_ERASE) && pendReg.accept) begin
          stateNext = ST_ERASE;
        end else begin
          stateNext = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (eraseDone) begin
          stateNext = ST_IDLE;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= ST_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // One region is erased a byte a cycle; commands wait meanwhile
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      eraseCntReg <= 8'h00;
    end else if (stateReg == ST_ERASE) begin
      eraseCntReg <= eraseCntReg + 8'h01;
    end else begin
      eraseCntReg <= 8'h00;
    end
  end

  // [R11] Region erase and program
  // Program only clears bits, so it is a read-modify-write
  assign memWrEn = (stateReg == ST_ERASE) ||
                   ((stateReg == ST_RESP) && (opReg == OP_SEC_PROG) &&
                    pendReg.accept);
  assign memWrAddr = (stateReg == ST_ERASE) ?
                     {pendReg.region, eraseCntReg} :
                     pendReg.addr[SEC_ADDR_W-1:0];
  assign memWrData = (stateReg == ST_ERASE) ? ERASED_BYTE :
                     (memRd & dataReg);

  sec_region_mem u_sec_mem (
    .sys_clk (sys_clk),
    .wrEn    (memWrEn),
    .wrAddr  (memWrAddr),
    .wrData  (memWrData),
    .rdEn    (take),
    .rdAddr  (effAddr[SEC_ADDR_W-1:0]),
    .rdData  (memRd)
  );

  // [R9] Parameter space, ID mirrored
  assign sigPos   = {pendReg.addr[1:0], 3'h0};
  assign sfdpByte = (pendReg.addr <= SFDP_SIG_LAST) ?
                    SFDP_SIGNATURE[sigPos +: 8] :
                    ((pendReg.addr >= SFDP_ID_BASE) &&
                     (pendReg.addr <= SFDP_ID_LAST)) ?
                    idByte(pendReg.addr[3:0]) : ERASED_BYTE;

  // [R7] Read-only ID space
  // [R8] Unique number bytes
  always_comb begin
    readByte = INVALID_BYTE;
    if (pendReg.accept) begin
      unique case (pendReg.space)
        SPACE_ID: begin
          readByte = (pendReg.addr <= ID_LAST_ADDR) ?
                     idByte(pendReg.addr[3:0]) : ERASED_BYTE;
        end
        SPACE_SFDP: readByte = sfdpByte;
        // [R15] Invalid data returned
        SPACE_SEC: begin
          readByte = pendReg.readProtected ? INVALID_BYTE : memRd;
        end
        SPACE_ARRAY: readByte = INVALID_BYTE;
      endcase
    end
  end

  // Response registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      respValidReg <= 1'b0;
      respReg      <= '0;
      readDataReg  <= 8'h00;
    end else begin
      respValidReg <= (stateReg == ST_RESP);
      if (stateReg == ST_RESP) begin
        respReg     <= pendReg;
        readDataReg <= readByte;
      end
    end
  end

  assign respValid = respValidReg;
  assign resp      = respReg;
  assign readData  = readDataReg;

  // [R16] Error flags, set wins
  assign progErrSet  = (stateReg == ST_RESP) && pendReg.protError &&
                       opIsProgram(opReg);
  assign eraseErrSet = (stateReg == ST_RESP) && pendReg.protError &&
                       opIsErase(opReg);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      progErrReg  <= 1'b0;
      eraseErrReg <= 1'b0;
    end else begin
      progErrReg  <= progErrSet || (progErrReg && !clearStatus);
      eraseErrReg <= eraseErrSet || (eraseErrReg && !clearStatus);
    end
  end

  always_comb begin
    statusTwoVolatile                = 8'h00;
    statusTwoVolatile[PROG_ERR_BIT]  = progErrReg;
    statusTwoVolatile[ERASE_ERR_BIT] = eraseErrReg;
  end

endmodule : flash_address_space_map

// [rtl/flash_map_pkg.sv]
package flash_map_pkg;

  // Address widths and byte counts
  localparam logic [2:0]  LEGACY_ADDR_BYTES = 3'h3;
  localparam logic [2:0]  EXT_ADDR_BYTES    = 3'h4;
  localparam int          LEGACY_ADDR_W     = 24;

  // Main array geometry
  localparam logic [31:0] ARRAY_LAST_ADDR = 32'h007F_FFFF;
  localparam int          ARRAY_MSB       = 22;
  localparam int          SECTOR_LSB      = 12;
  localparam int          HALF_LSB        = 15;
  localparam int          BLOCK_LSB       = 16;
  localparam logic [31:0] SECTOR_MASK     = 32'h0000_0FFF;
  localparam logic [31:0] HALF_MASK       = 32'h0000_7FFF;
  localparam logic [31:0] BLOCK_MASK      = 32'h0000_FFFF;

  // Security regions
  localparam int          SEC_SPACE_BYTES = 1024;
  localparam int          SEC_ADDR_W      = 10;
  localparam int          REGION_LSB      = 8;
  localparam logic [31:0] SEC_LAST_ADDR   = 32'h0000_03FF;
  localparam logic [31:0] REGION_MASK     = 32'h0000_00FF;
  localparam logic [7:0]  REGION_LAST_OFS = 8'hFF;
  localparam logic [1:0]  TEMP_PROT_FIRST = 2'h2;
  localparam logic [1:0]  READ_PROT_REGION = 2'h3;

  // Configuration and protection bit positions
  localparam int LOCK_LSB      = 2;
  localparam int PWD_PROT_BIT  = 2;
  localparam int READ_PROT_BIT = 6;
  localparam int PROG_ERR_BIT  = 6;
  localparam int ERASE_ERR_BIT = 5;

  // Byte values
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam logic [7:0] INVALID_BYTE = 8'h00;

  // Identification and discoverable parameter spaces
  localparam logic [31:0] ID_LAST_ADDR   = 32'h0000_000F;
  localparam logic [31:0] SFDP_SIG_LAST  = 32'h0000_0003;
  localparam logic [31:0] SFDP_SIGNATURE = 32'h5044_4653;
  localparam logic [31:0] SFDP_ID_BASE   = 32'h0000_0100;
  localparam logic [31:0] SFDP_ID_LAST   = 32'h0000_010F;

  typedef enum logic [3:0] {
    OP_ARRAY_READ   = 4'h0,
    OP_ARRAY_PROG   = 4'h1,
    OP_SECTOR_ERASE = 4'h2,
    OP_HALF_ERASE   = 4'h3,
    OP_BLOCK_ERASE  = 4'h4,
    OP_ID_READ      = 4'h5,
    OP_SFDP_READ    = 4'h6,
    OP_SEC_READ     = 4'h7,
    OP_SEC_PROG     = 4'h8,
    OP_SEC_ERASE    = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    SPACE_ARRAY = 2'h0,
    SPACE_ID    = 2'h1,
    SPACE_SFDP  = 2'h2,
    SPACE_SEC   = 2'h3
  } space_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RESP  = 3'b010,
    ST_ERASE = 3'b100
  } state_t;

  typedef struct packed {
    op_t         op;
    logic        fourByte;
    logic [2:0]  addrBytes;
    logic [31:0] addr;
    logic [7:0]  data;
  } cmd_req_t;

  typedef struct packed {
    space_t      space;
    logic        accept;
    logic        addrError;
    logic        rangeError;
    logic        protError;
    logic        readProtected;
    logic [1:0]  region;
    logic [31:0] addr;
    logic [31:0] eraseBase;
    logic [10:0] sectorIndex;
    logic [7:0]  halfBlockIndex;
    logic [6:0]  blockIndex;
  } map_resp_t;

endpackage : flash_map_pkg

// [rtl/sec_region_mem.sv]
module sec_region_mem
  import flash_map_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  wrEn,
  input  wire logic [SEC_ADDR_W-1:0] wrAddr,
  input  wire logic [7:0]            wrData,
  input  wire logic                  rdEn,
  input  wire logic [SEC_ADDR_W-1:0] rdAddr,
  output logic      [7:0]            rdData
);

  logic [7:0] mem [SEC_SPACE_BYTES];

  // Regions start out erased
  initial begin
    for (int i = 0; i < SEC_SPACE_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : sec_region_mem

// [test/flash_address_space_map_props.sv]
module flash_map_props
  import flash_map_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       extAddrDefault,
  input wire logic       extAddrMode,
  input wire logic [7:0] configOneNonvolatile,
  input wire logic       volatileRegionLock,
  input wire logic       cmdValid,
  input wire logic       cmdReady,
  input wire cmd_req_t   cmdReq,
  input wire logic       respValid,
  input wire map_resp_t  resp,
  input wire logic [7:0] readData,
  input wire logic [7:0] statusTwoVolatile
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_resp_latency:
    assert property (cmdValid && cmdReady |=> !cmdReady ##1 respValid)
    else $error("response not two cycles after take");
  a_addr_width:
    assert property (respValid |-> resp.addrError == ($past(cmdReq.addrBytes,
      2) != (($past(cmdReq.fourByte, 2) || $past(extAddrMode, 2)) ? 3'h4
      : 3'h3))) else $error("address width check wrong");
  a_mode_reload:
    assert property (!$past(arst_n) |=> extAddrMode == $past(extAddrDefault))
    else $error("extended mode not loaded after reset");
  a_index_fields:
    assert property (respValid |-> resp.sectorIndex == resp.addr[22:12] &&
      resp.halfBlockIndex == resp.addr[22:15] &&
      resp.blockIndex == resp.addr[22:16]) else $error("index fields wrong");
  a_erase_align:
    assert property (respValid && resp.accept && $past(cmdReq.op, 2) inside
      {OP_SECTOR_ERASE, OP_HALF_ERASE, OP_BLOCK_ERASE} |-> resp.eraseBase ==
      (resp.addr & ~(($past(cmdReq.op, 2) == OP_SECTOR_ERASE) ? SECTOR_MASK :
      ($past(cmdReq.op, 2) == OP_HALF_ERASE) ? HALF_MASK : BLOCK_MASK)))
    else $error("erase base not aligned");
  a_hidden_read:
    assert property (respValid && resp.readProtected |-> readData == 8'h00)
    else $error("protected read leaked data");
  a_lock_blocks:
    assert property (respValid && resp.space == SPACE_SEC &&
      !resp.addrError && !resp.rangeError &&
      ((($past(configOneNonvolatile, 2) >> (LOCK_LSB + resp.region)) &
      8'h01) != 8'h00) &&
      $past(cmdReq.op, 2) inside {OP_SEC_PROG, OP_SEC_ERASE} |->
      !resp.accept && resp.protError) else $error("locked region modified");
  a_temp_lock:
    assert property (respValid && resp.space == SPACE_SEC && resp.region[1] &&
      !resp.addrError && !resp.rangeError && $past(volatileRegionLock, 2) &&
      $past(cmdReq.op, 2) inside {OP_SEC_PROG, OP_SEC_ERASE} |->
      resp.protError) else $error("region lock ignored");
  a_error_flag:
    assert property (respValid && resp.protError |-> ##[0:1]
      (statusTwoVolatile & 8'h60) != 8'h00) else $error("error flag not set");
endmodule : flash_map_props

bind flash_address_space_map flash_map_props chk (.sys_clk, .arst_n,
  .extAddrDefault, .extAddrMode, .configOneNonvolatile, .volatileRegionLock,
  .cmdValid, .cmdReady, .cmdReq, .respValid, .resp, .readData,
  .statusTwoVolatile);

// [test/host_cmd_model.sv]
module host_cmd_model
  import flash_map_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       extAddrMode,
  input wire logic       cmdReady,
  output logic           cmdValid,
  output cmd_req_t       cmdReq,
  input wire logic       respValid,
  input wire map_resp_t  resp,
  input wire logic [7:0] readData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdReq = '0;
  end

  task automatic issue(input op_t op, input logic fb, input logic bad,
    input logic [31:0] a, input logic [7:0] d, output map_resp_t r,
    output logic [7:0] rd);
    logic [2:0] nb;
    @(negedge sys_clk);
    nb = (fb || extAddrMode) ? EXT_ADDR_BYTES : LEGACY_ADDR_BYTES;
    cmdReq = '{op, fb, bad ? nb ^ 3'h7 : nb, a, d};
    cmdValid = 1'b1;
    #1;
    while (!cmdReady) begin
      @(negedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmdValid = 1'b0;
    // Released lines do not keep their last value
    cmdReq = cmd_req_t'(~cmdReq);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      #1;
      if (respValid) break;
    end
    r = resp;
    rd = readData;
  endtask : issue
endmodule : host_cmd_model

// [test/flash_address_space_map_test.sv]
module flash_address_space_map_test
  import flash_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary serial number
  localparam logic [63:0] UID = 64'h1122_3344_5566_7788;
  logic sys_clk = 1'b0, arst_n = 1'b0, softReset = 1'b0;
  logic extAddrDefault = 1'b0, extAddrWrite = 1'b0, extAddrValue = 1'b0;
  logic volatileRegionLock = 1'b0, passwordOk = 1'b0, clearStatus = 1'b0;
  logic [7:0] configOneNonvolatile = 8'h00;
  logic [15:0] regionProtectionReg = 16'h0000;
  logic extAddrMode, cmdValid, cmdReady, respValid, busy;
  cmd_req_t cmdReq;
  map_resp_t resp, r;
  logic [7:0] readData, statusTwoVolatile, rd;
  int errors = 0, nTests = 0;

  always #4 sys_clk = ~sys_clk;

  flash_address_space_map #(.UNIQUE_ID(UID)) uut (.sys_clk, .arst_n,
    .softReset, .extAddrDefault, .extAddrWrite, .extAddrValue, .extAddrMode,
    .configOneNonvolatile, .volatileRegionLock, .regionProtectionReg,
    .passwordOk, .cmdValid, .cmdReady, .cmdReq, .respValid, .resp,
    .readData, .busy, .clearStatus, .statusTwoVolatile);
  host_cmd_model host (.sys_clk, .extAddrMode, .cmdReady, .cmdValid,
    .cmdReq, .respValid, .resp, .readData);

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cmd(op_t op, logic fb, logic bad, logic [31:0] a,
    logic [7:0] d = 8'h00);
    host.issue(op, fb, bad, a, d, r, rd);
  endtask : cmd

  task automatic set_mode(logic v);
    @(negedge sys_clk);
    extAddrWrite = 1'b1;
    extAddrValue = v;
    @(negedge sys_clk);
    extAddrWrite = 1'b0;
  endtask : set_mode

  task automatic set_prot(logic [7:0] cfg, logic lk, logic [15:0] region_protection_reg,
    logic pw);
    @(negedge sys_clk);
    configOneNonvolatile = cfg;
    volatileRegionLock = lk;
    regionProtectionReg = region_protection_reg;
    passwordOk = pw;
  endtask : set_prot

  task automatic t_mode;
    check("extAddrMode", 0, extAddrMode);
    @(negedge sys_clk);
    extAddrDefault = 1'b1;
    softReset = 1'b1;
    @(negedge sys_clk);
    softReset = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("extAddrMode", 1, extAddrMode);
    set_mode(1'b0);
    check("extAddrMode", 0, extAddrMode);
    // Mid-run hard reset must reload the default as well
    @(negedge sys_clk) arst_n = 1'b0;
    @(negedge sys_clk) arst_n = 1'b1;
    check("extAddrMode", 0, extAddrMode);
    check("cmdReady", 0, cmdReady);
    repeat (2) @(negedge sys_clk);
    check("extAddrMode", 1, extAddrMode);
    set_mode(1'b0);
    check("extAddrMode", 0, extAddrMode);
    $display("t_mode done");
  endtask : t_mode

  task automatic t_width;
    cmd(OP_ARRAY_READ, 0, 0, 32'hAB01_2345);
    check("addr", 32'h0001_2345, r.addr);
    check("addrError", 0, r.addrError);
    cmd(OP_ARRAY_READ, 0, 1, 32'h0001_2345);
    check("addrError", 1, r.addrError);
    cmd(OP_ARRAY_READ, 1, 0, 32'h0000_1000);
    check("addrError", 0, r.addrError);
    cmd(OP_ID_READ, 1, 1, 32'h0000_0008);
    check("addrError", 1, r.addrError);
    set_mode(1'b1);
    cmd(OP_ARRAY_READ, 0, 1, 32'h0070_0000);
    check("addrError", 1, r.addrError);
    cmd(OP_ARRAY_READ, 0, 0, 32'h0070_0000);
    check("addr", 32'h0070_0000, r.addr);
    set_mode(1'b0);
    $display("t_width done");
  endtask : t_width

  task automatic t_geom;
    op_t ops[3] = '{OP_SECTOR_ERASE, OP_HALF_ERASE, OP_BLOCK_ERASE};
    logic [31:0] base[3] = '{32'h007F_F000, 32'h007F_8000, 32'h007F_0000};
    for (int i = 0; i < 3; i++) begin
      cmd(ops[i], 0, 0, 32'h007F_FFFF);
      check("eraseBase", base[i], r.eraseBase);
    end
    check("sectorIndex", 2047, r.sectorIndex);
    check("halfBlockIndex", 255, r.halfBlockIndex);
    check("blockIndex", 127, r.blockIndex);
    cmd(OP_ARRAY_READ, 0, 0, 32'h0080_0000);
    check("rangeError", 1, r.rangeError);
    $display("t_geom done");
  endtask : t_geom

  task automatic t_ident;
    for (int i = 0; i < 8; i++) begin
      cmd(OP_ID_READ, 0, 0, 32'(8 + i));
      check("uniqueId", UID[8*i+:8], rd);
    end
    check("space", SPACE_ID, r.space);
    for (int i = 0; i < 4; i++) begin
      cmd(OP_SFDP_READ, 0, 0, 32'(i));
      check("signature", SFDP_SIGNATURE[8*i+:8], rd);
    end
    cmd(OP_SFDP_READ, 0, 0, 32'h0000_0108);
    check("sfdpId", UID[7:0], rd);
    $display("t_ident done");
  endtask : t_ident

  task automatic t_sec;
    int n;
    cmd(OP_SEC_READ, 0, 0, 32'h0FF);
    check("fresh", 8'hFF, rd);
    cmd(OP_SEC_PROG, 0, 0, 32'h1A0, 8'h5A);
    cmd(OP_SEC_READ, 0, 0, 32'h1A0);
    check("programmed", 8'h5A, rd);
    check("region", 1, r.region);
    cmd(OP_SEC_ERASE, 0, 0, 32'h1A0);
    check("busy", 1, busy);
    n = 0;
    while (!cmdReady && n < 400) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("eraseCycles", 256, n);
    check("busy", 0, busy);
    cmd(OP_SEC_READ, 0, 0, 32'h1A0);
    check("erased", 8'hFF, rd);
    cmd(OP_SEC_READ, 0, 0, 32'h400);
    check("rangeError", 1, r.rangeError);
    set_prot(8'h04, 1'b0, 16'h0000, 1'b0);
    cmd(OP_SEC_PROG, 0, 0, 32'h010);
    check("protError", 1, r.protError);
    @(negedge sys_clk);
    check("status", 8'h40, statusTwoVolatile);
    clearStatus = 1'b1;
    @(negedge sys_clk);
    clearStatus = 1'b0;
    cmd(OP_SEC_ERASE, 0, 0, 32'h010);
    @(negedge sys_clk);
    check("status", 8'h20, statusTwoVolatile);
    // Clear held high while a new error lands: the set must win
    clearStatus = 1'b1;
    cmd(OP_SEC_PROG, 0, 0, 32'h010);
    check("setWins", 8'h40, statusTwoVolatile);
    @(negedge sys_clk);
    clearStatus = 1'b0;
    set_prot(8'h04, 1'b1, 16'h0000, 1'b0);
    cmd(OP_SEC_PROG, 0, 0, 32'h210);
    check("protError", 1, r.protError);
    set_prot(8'h04, 1'b0, 16'h0044, 1'b0);
    cmd(OP_SEC_PROG, 0, 0, 32'h310, 8'h3C);
    check("protError", 1, r.protError);
    set_prot(8'h04, 1'b0, 16'h0044, 1'b1);
    cmd(OP_SEC_PROG, 0, 0, 32'h310, 8'h3C);
    check("accept", 1, r.accept);
    set_prot(8'h04, 1'b1, 16'h0044, 1'b1);
    cmd(OP_SEC_PROG, 0, 0, 32'h310, 8'h00);
    check("protError", 1, r.protError);
    set_prot(8'h04, 1'b0, 16'h0044, 1'b0);
    cmd(OP_SEC_READ, 0, 0, 32'h310);
    check("hidden", 8'h00, rd);
    set_prot(8'h04, 1'b0, 16'h0044, 1'b1);
    cmd(OP_SEC_READ, 0, 0, 32'h310);
    check("unlocked", 8'h3C, rd);
    $display("t_sec done");
  endtask : t_sec

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_mode();
    t_width();
    t_geom();
    t_ident();
    t_sec();
    close_out();
  end

  // Whole run needs a few thousand cycles at most
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule : flash_address_space_map_test
